// File: dv/testbench.sv
// self-checking bench for the pulse program sequencer
`timescale 1ns/1ps
`include "pps_defines.svh"
module testbench
  import pps_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hw_trigger = 1'b0;
  logic hw_reset = 1'b0;
  logic [31:0] rdata;
  logic [15:0] flags;
  logic [1:0] rf_gate;
  logic [1:0] phase_zero;
  logic [15:0] freq_sel;
  logic [13:0] phase_sel;
  logic [13:0] amp_sel;
  logic [5:0] env_period_sel;
  logic env_en;
  logic [15:0] last_flags = 16'h0;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int last_t = 0;
  bit arm = 1'b0;
  inst_s prog [16];
  int aq[$];
  int dq[$];
  logic [127:0] v;

  always #20 core_clk = ~core_clk;

  pulse_program_sequencer dut (
    .core_clk(core_clk),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .hw_trigger(hw_trigger),
    .hw_reset(hw_reset),
    .flags(flags),
    .rf_gate(rf_gate),
    .phase_zero(phase_zero),
    .freq_sel(freq_sel),
    .phase_sel(phase_sel),
    .amp_sel(amp_sel),
    .env_period_sel(env_period_sel),
    .env_en(env_en)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic conclude();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk({48'h0, rdata}, {48'h0, exp});
  endtask

  task automatic wait_flags(input logic [15:0] f);
    int n;
    n = 0;
    while (flags !== f && n < 300) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  function automatic inst_s mk(input logic [3:0] a, input opcode_e op,
    input logic [19:0] arg, input logic [31:0] d);
    inst_s w;
    w.flags = {12'hA00, a};
    w.rf_gate = a[1:0];
    w.phase_rst = a[2:1];
    w.freq0 = {4'hC, a};
    w.freq1 = {4'h3, ~a};
    w.ph0 = {3'h1, a};
    w.ph1 = {3'h6, ~a};
    w.amp0 = {3'h5, a};
    w.amp1 = {3'h2, ~a};
    w.shape_en = a[0];
    w.shp0 = 3'(a % 4'h7);
    w.shp1 = 3'(4'h6 - a % 4'h7);
    w.op = op;
    w.arg = arg;
    w.delay = d;
    return w;
  endfunction

  function automatic logic [79:0] expect_out(input inst_s w);
    return {9'h0, w.rf_gate, w.phase_rst, w.freq1, w.freq0, w.ph1, w.ph0, w.amp1, w.amp0,
      (w.shape_en ? {w.shp1, w.shp0} : 6'h00), w.shape_en, w.flags};
  endfunction

  function automatic int dur(input int a);
    return (a == 0) ? 3 : ((a == 5 || a == 10) ? 6 : 2);
  endfunction

  // ----------------------------------------
  // output monitor and timeout
  // ----------------------------------------
  always @(negedge core_clk) begin
    if (!rst && flags !== last_flags) begin
      chk({9'h0, rf_gate, phase_zero, freq_sel, phase_sel, amp_sel, env_period_sel, env_en,
        flags}, expect_out(prog[flags[3:0]]));
      aq.push_back(int'(flags[3:0]));
      if (arm) begin
        dq.push_back(cyc - last_t);
      end
      arm = 1'b1;
      last_t = cyc;
      last_flags = flags;
    end
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ----------------------------------------
  // one pass over the program
  // ----------------------------------------
  task automatic run(input bit sw, input string name);
    int exp_a[$] = '{0, 1, 2, 3, 2, 3, 4, 9, 5, 6, 7, 10};
    aq.delete();
    dq.delete();
    arm = 1'b0;
    wr_reg(`REG_CTRL, 32'h1);
    rd_reg(`REG_STATUS, 32'h4);
    wait_flags(16'hA006);
    repeat (10) @(posedge core_clk);
    rd_reg(`REG_STATUS, 32'h8);
    chk(80'(flags), 80'hA006);
    if (sw) begin
      wr_reg(`REG_CTRL, 32'h4);
    end else begin
      @(posedge core_clk);
      hw_trigger <= 1'b1;
      @(posedge core_clk);
      hw_trigger <= 1'b0;
    end
    wait_flags(16'hA00A);
    repeat (12) @(posedge core_clk);
    rd_reg(`REG_STATUS, 32'h1);
    chk(80'(flags), 80'hA00A);
    chk(80'(aq.size()), 80'(exp_a.size()));
    for (int i = 0; i < exp_a.size() && i < aq.size(); i++) begin
      chk(80'(aq[i]), 80'(exp_a[i]));
    end
    for (int i = 0; i < dq.size() && i < exp_a.size(); i++) begin
      if (exp_a[i] != 6) begin
        chk(80'(dq[i]), 80'(dur(exp_a[i])));
      end
    end
    $display("test %s done", name);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    prog[0] = mk(4'h0, OP_CONTINUE, 20'h0, 32'h3);
    prog[1] = mk(4'h1, OP_LOOP, 20'h2, 32'h2);
    prog[2] = mk(4'h2, OP_CONTINUE, 20'h0, 32'h2);
    prog[3] = mk(4'h3, OP_END_LOOP, 20'h2, 32'h2);
    prog[4] = mk(4'h4, OP_SUBROUTINE_CALL, 20'h9, 32'h2);
    prog[5] = mk(4'h5, OP_LONG_DELAY, 20'h2, 32'h3);
    prog[6] = mk(4'h6, OP_WAIT, 20'h0, 32'h2);
    prog[7] = mk(4'h7, OP_BRANCH, 20'hA, 32'h2);
    prog[8] = mk(4'h8, OP_STOP, 20'h0, 32'h2);
    prog[9] = mk(4'h9, OP_SUBROUTINE_RETURN, 20'h0, 32'h2);
    prog[10] = mk(4'hA, OP_CONTINUE, 20'h0, 32'h6);
    prog[11] = mk(4'hB, OP_STOP, 20'h0, 32'h2);
    prog[8].flags = 16'h5555;
    prog[11].flags = 16'h5555;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    chk(80'(flags), 80'h0);
    rd_reg(`REG_STATUS, 32'h2);
    rd_reg(`REG_PC, 32'h0);
    rd_reg(8'h40, 32'h0);
    wr_reg(`REG_MEM_ADDR, 32'h0);
    for (int i = 0; i < 12; i++) begin
      v = {1'b0, prog[i]};
      wr_reg(`REG_MEM_DATA0, v[127:96]);
      wr_reg(`REG_MEM_DATA0, v[95:64]);
      wr_reg(`REG_MEM_DATA0, v[63:32]);
      wr_reg(8'h14, v[31:0]);
    end
    $display("test reset and load done");
    run(1'b0, "hardware trigger");
    run(1'b1, "software trigger");
    @(posedge core_clk);
    hw_reset <= 1'b1;
    @(posedge core_clk);
    hw_reset <= 1'b0;
    rd_reg(`REG_STATUS, 32'h2);
    rd_reg(`REG_PC, 32'h0);
    chk(80'(flags), 80'hA00A);
    $display("test sequencer reset done");
    conclude();
  end
endmodule

// File: logic/pps_call_stack.sv
// return-address stack and loop-counter stack
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_call_stack
  import pps_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  pps_if.stk s,
  pps_if.lp l
);
  logic [9:0] ret_mem [0:`STACK_DEPTH-1];
  logic [19:0] cnt_mem [0:`LOOP_DEPTH-1];
  logic [2:0] rsp;
  logic [2:0] lsp;
  assign s.top_addr = ret_mem[rsp - 3'h1];
  assign l.loop_top = cnt_mem[lsp - 3'h1];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp <= 3'h0;
    end else if (clr) begin
      rsp <= 3'h0;
    end else if (s.push) begin
      rsp <= rsp + 3'h1;
    end else if (s.pop) begin
      rsp <= rsp - 3'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (s.push) begin
      ret_mem[rsp] <= s.push_addr;
    end
    if (l.loop_load) begin
      cnt_mem[lsp] <= l.loop_count;
    end else if (l.loop_dec) begin
      cnt_mem[lsp - 3'h1] <= l.loop_top - 20'h00001;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lsp <= 3'h0;
    end else if (clr) begin
      lsp <= 3'h0;
    end else if (l.loop_load) begin
      lsp <= lsp + 3'h1;
    end else if (l.loop_pop) begin
      lsp <= lsp - 3'h1;
    end
  end
endmodule

// File: logic/pps_defines.svh
// constants for the pulse program sequencer
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH
`define CLK_MHZ 25
`define ADDR_W 10
`define MEM_DEPTH 1024
`define WORD_W 128
`define ARG_W 20
`define DLY_W 32
`define LOOP_DEPTH 8
`define STACK_DEPTH 8
`define MIN_INTERVAL 2
// register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PC 8'h08
`define REG_MEM_ADDR 8'h0C
`define REG_MEM_DATA0 8'h10
// control bits
`define CTRL_START 0
`define CTRL_RESET 1
`define CTRL_TRIG 2
// status bits
`define ST_STOPPED 0
`define ST_RESET 1
`define ST_RUNNING 2
`define ST_WAITING 3
// instruction word fields
`define F_FLAGS_LO 0
`define F_OE_LO 16
`define F_PRST_LO 18
`define F_FREQ0_LO 20
`define F_FREQ1_LO 28
`define F_PH0_LO 36
`define F_PH1_LO 43
`define F_AMP0_LO 50
`define F_AMP1_LO 57
`define F_SHP0_LO 64
`define F_SHP1_LO 67
`define F_SHAPE_EN 70
`define F_OP_LO 71
`define F_ARG_LO 75
`define F_DLY_LO 95
`endif

// File: logic/pps_field_latch.sv
// output latch for the per-instruction flags and synthesizer selects
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_field_latch
  import pps_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire inst_s word,
  output logic [15:0] flags,
  output logic [1:0] rf_gate,
  output logic [1:0] phase_zero,
  output logic [15:0] freq_sel,
  output logic [13:0] phase_sel,
  output logic [13:0] amp_sel,
  output logic [5:0] env_period_sel,
  output logic env_en
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags <= 16'h0000;
      rf_gate <= 2'h0;
      phase_zero <= 2'h0;
      freq_sel <= 16'h0000;
      phase_sel <= 14'h0000;
      amp_sel <= 14'h0000;
      env_period_sel <= 6'h00;
      env_en <= 1'b0;
    end else if (load) begin
      flags <= word.flags;
      rf_gate <= word.rf_gate;
      phase_zero <= word.phase_rst;
      freq_sel <= {word.freq1, word.freq0};
      phase_sel <= {word.ph1, word.ph0};
      amp_sel <= {word.amp1, word.amp0};
      env_period_sel <= word.shape_en ? {word.shp1, word.shp0} : 6'h00;
      env_en <= word.shape_en;
    end
  end
endmodule

// File: logic/pps_if.sv
// flow-control stack link between sequencer and stack modules
`timescale 1ns/1ps
interface pps_if;
  logic push;
  logic pop;
  logic [9:0] push_addr;
  logic [9:0] top_addr;
  logic loop_load;
  logic loop_dec;
  logic loop_pop;
  logic [19:0] loop_count;
  logic [19:0] loop_top;
  modport seq (output push, pop, push_addr, loop_load, loop_dec, loop_pop, loop_count,
    input top_addr, loop_top);
  modport stk (input push, pop, push_addr, output top_addr);
  modport lp (input loop_load, loop_dec, loop_pop, loop_count, output loop_top);
endinterface

// File: logic/pps_pkg.sv
// types of the pulse program sequencer
package pps_pkg;
  typedef enum logic [3:0] {
    OP_CONTINUE = 4'h0,
    OP_STOP = 4'h1,
    OP_LOOP = 4'h2,
    OP_END_LOOP = 4'h3,
    OP_SUBROUTINE_CALL = 4'h4,
    OP_SUBROUTINE_RETURN = 4'h5,
    OP_BRANCH = 4'h6,
    OP_LONG_DELAY = 4'h7,
    OP_WAIT = 4'h8
  } opcode_e;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_FETCH = 5'h02,
    ST_HOLD = 5'h04,
    ST_PAUSE = 5'h08,
    ST_HALT = 5'h10
  } seq_state_e;
  typedef struct packed {
    logic [31:0] delay;
    logic [19:0] arg;
    logic [3:0] op;
    logic shape_en;
    logic [2:0] shp1;
    logic [2:0] shp0;
    logic [6:0] amp1;
    logic [6:0] amp0;
    logic [6:0] ph1;
    logic [6:0] ph0;
    logic [7:0] freq1;
    logic [7:0] freq0;
    logic [1:0] phase_rst;
    logic [1:0] rf_gate;
    logic [15:0] flags;
  } inst_s;
endpackage

// File: logic/pulse_program_sequencer.sv
// pulse program sequencer: instruction memory, decoder and flow control
// ----------------------------------------------------------------
// How it works
// - opcode field decoded as 0..8, one flow behaviour each
// - each word except opcode 1 drives 16 output flags for its interval
// - one rf gate bit per channel enables that channel
// - per-channel phase-zero request resets accumulator during instruction
// - per-channel frequency, phase and amplitude indices are driven out
// - envelope variant adds per-channel envelope-period index
// - outputs hold for the interval before flow decision
// - opcode 0 advances to the next address
// - opcode 1 halts into the stopped state
// - on halt outputs keep the previous instruction values
// - opcode 2 loads loop counter from argument, then continues
// - opcode 3 decrements counter and returns to argument address while it exceeds 1, else pops it and continues
// - opcode 4 saves return point and jumps to argument
// - opcode 5 resumes after the latest call
// - opcode 6 jumps to argument address
// - opcode 7 multiplies interval by argument, then continues
// - opcode 8 pauses until software or hardware trigger
// - index fields wide for 256, 128, 128 and 8 registers
// - status bits 0..3: stopped, reset, running, waiting
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "pps_defines.svh"
module pulse_program_sequencer
  import pps_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic hw_trigger,
  input wire logic hw_reset,
  output logic [15:0] flags,
  output logic [1:0] rf_gate,
  output logic [1:0] phase_zero,
  output logic [15:0] freq_sel,
  output logic [13:0] phase_sel,
  output logic [13:0] amp_sel,
  output logic [5:0] env_period_sel,
  output logic env_en
);
  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  seq_state_e state;
  logic [9:0] pc;
  logic [`WORD_W-1:0] imem [0:`MEM_DEPTH-1];
  inst_s cur;
  logic [31:0] dly_cnt;
  logic [19:0] mult_cnt;
  logic [9:0] mem_addr;
  logic [95:0] stage;
  logic sw_start;
  logic sw_reset;
  logic sw_trig;
  logic load;
  logic hold_done;
  logic flow_go;
  logic [9:0] next_pc;
  seq_state_e next_state;
  pps_if link();

  function automatic logic [9:0] arg_addr(input logic [19:0] a);
    arg_addr = a[9:0];
  endfunction

  assign sw_start = wr && addr == `REG_CTRL && wdata[`CTRL_START];
  assign sw_reset = (wr && addr == `REG_CTRL && wdata[`CTRL_RESET]) || hw_reset;
  assign sw_trig = (wr && addr == `REG_CTRL && wdata[`CTRL_TRIG]) || hw_trigger;
  assign cur = inst_s'(imem[pc][126:0]);

  // ----------------------------------------------------------------
  // instruction memory load
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_addr <= 10'h000;
      stage <= 96'h0;
    end else if (wr && addr == `REG_MEM_ADDR) begin
      mem_addr <= wdata[9:0];
    end else if (wr && addr == `REG_MEM_DATA0) begin
      stage <= {stage[63:0], wdata};
    end else if (wr && addr == `REG_MEM_DATA0 + 8'h04) begin
      mem_addr <= mem_addr + 10'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr && addr == `REG_MEM_DATA0 + 8'h04) begin
      imem[mem_addr] <= {stage, wdata};
    end
  end

  // ----------------------------------------------------------------
  // flow control decision
  // ----------------------------------------------------------------
  always_comb begin
    next_pc = pc + 10'h001;
    next_state = ST_FETCH;
    link.push = 1'b0;
    link.pop = 1'b0;
    link.push_addr = pc + 10'h001;
    link.loop_load = 1'b0;
    link.loop_dec = 1'b0;
    link.loop_pop = 1'b0;
    link.loop_count = cur.arg;
    case (opcode_e'(cur.op))
      OP_CONTINUE: begin
        next_pc = pc + 10'h001;
      end
      OP_STOP: begin
        next_pc = pc;
        next_state = ST_HALT;
      end
      OP_LOOP: begin
        link.loop_load = flow_go;
      end
      OP_END_LOOP: begin
        if (link.loop_top > 20'h00001) begin
          link.loop_dec = flow_go;
          next_pc = arg_addr(cur.arg);
        end else begin
          link.loop_pop = flow_go;
        end
      end
      OP_SUBROUTINE_CALL: begin
        link.push = flow_go;
        next_pc = arg_addr(cur.arg);
      end
      OP_SUBROUTINE_RETURN: begin
        link.pop = flow_go;
        next_pc = link.top_addr;
      end
      OP_BRANCH: begin
        next_pc = arg_addr(cur.arg);
      end
      OP_LONG_DELAY: begin
        next_pc = pc + 10'h001;
      end
      OP_WAIT: begin
        next_pc = pc + 10'h001;
        next_state = ST_PAUSE;
      end
      default: begin
        next_pc = pc;
        next_state = ST_HALT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer state machine
  // ----------------------------------------------------------------
  assign hold_done = state == ST_HOLD && dly_cnt <= 32'h1 && mult_cnt <= 20'h00001;
  assign flow_go = hold_done;
  assign load = state == ST_FETCH && cur.op != OP_STOP;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      pc <= 10'h000;
    end else if (sw_reset) begin
      state <= ST_IDLE;
      pc <= 10'h000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (sw_start || sw_trig) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state <= ST_HOLD;
        end
        ST_HOLD: begin
          if (flow_go) begin
            state <= next_state;
            pc <= next_pc;
          end
        end
        ST_PAUSE: begin
          if (sw_trig) begin
            state <= ST_FETCH;
          end
        end
        ST_HALT: begin
          if (sw_start || sw_trig) begin
            state <= ST_FETCH;
            pc <= 10'h000;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // interval counters; long delay repeats the interval arg times
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dly_cnt <= 32'h0;
      mult_cnt <= 20'h00000;
    end else if (state == ST_FETCH) begin
      dly_cnt <= (cur.delay < `MIN_INTERVAL) ? 32'(`MIN_INTERVAL) - 32'h1 : cur.delay - 32'h1;
      mult_cnt <= (opcode_e'(cur.op) == OP_LONG_DELAY) ? cur.arg : 20'h00001;
    end else if (state == ST_HOLD) begin
      if (dly_cnt > 32'h1) begin
        dly_cnt <= dly_cnt - 32'h1;
      end else if (mult_cnt > 20'h00001) begin
        mult_cnt <= mult_cnt - 20'h00001;
        dly_cnt <= (cur.delay < `MIN_INTERVAL) ? 32'(`MIN_INTERVAL) : cur.delay;
      end
    end
  end

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  pps_call_stack u_stack (
    .core_clk(core_clk),
    .rst(rst),
    .clr(sw_reset),
    .s(link.stk),
    .l(link.lp)
  );

  // outputs change only on fetch, so halt keeps the last values
  pps_field_latch u_latch (
    .core_clk(core_clk),
    .rst(rst),
    .load(load),
    .word(cur),
    .flags(flags),
    .rf_gate(rf_gate),
    .phase_zero(phase_zero),
    .freq_sel(freq_sel),
    .phase_sel(phase_sel),
    .amp_sel(amp_sel),
    .env_period_sel(env_period_sel),
    .env_en(env_en)
  );

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [3:0] status;
  assign status = {state == ST_PAUSE, state == ST_FETCH || state == ST_HOLD,
    state == ST_IDLE, state == ST_HALT};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `REG_STATUS: rdata <= {28'h0, status};
        `REG_PC: rdata <= {22'h0, pc};
        `REG_MEM_ADDR: rdata <= {22'h0, mem_addr};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // index widths: freq 8 bits, phase/amp 7 bits, envelope 3 bits per channel
  a_fetch_to_hold: assert property (@(posedge core_clk) disable iff (rst || sw_reset)
    state == ST_FETCH |=> state == ST_HOLD) else $error("fetch not followed by hold");
  a_halt_keeps_out: assert property (@(posedge core_clk) disable iff (rst)
    state == ST_HALT && $past(state) == ST_HALT |-> $stable(flags))
    else $error("outputs changed while halted");
  a_stop_halts: assert property (@(posedge core_clk) disable iff (rst || sw_reset)
    hold_done && cur.op == 4'h1 |=> state == ST_HALT) else $error("stop did not halt");
  a_branch_pc: assert property (@(posedge core_clk) disable iff (rst || sw_reset)
    hold_done && cur.op == 4'h6 |=> pc == $past(cur.arg[9:0])) else $error("branch target wrong");
  a_cont_pc: assert property (@(posedge core_clk) disable iff (rst || sw_reset)
    hold_done && cur.op == 4'h0 |=> pc == $past(pc) + 10'h001) else $error("continue pc wrong");
  a_wait_pause: assert property (@(posedge core_clk) disable iff (rst || sw_reset)
    state == ST_PAUSE && !sw_trig |=> state == ST_PAUSE) else $error("wait left without trigger");
  a_flags_load: assert property (@(posedge core_clk) disable iff (rst)
    load |=> flags == $past(cur.flags)) else $error("flags not loaded");
  a_status_onehot: assert property (@(posedge core_clk) disable iff (rst)
    $onehot(status)) else $error("status not one-hot");
  c_halt: cover property (@(posedge core_clk) state == ST_HALT);
  c_pause: cover property (@(posedge core_clk) state == ST_PAUSE);
  c_call: cover property (@(posedge core_clk) hold_done && cur.op == 4'h4);
endmodule
